// file: core/cfg_word_one_pkg.sv
// constants for the second configuration word decoder
// assumes a single core_clk domain and an axi4-lite register bus
package cfg_word_one_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] ADDR_CFG_WORD   = 8'h00;
  localparam logic [7:0] ADDR_WDT_CTRL   = 8'h04;
  localparam logic [7:0] ADDR_STATUS     = 8'h08;

  // ==========================================================
  // field positions of the configuration word
  localparam int WDT_FORCE_BIT   = 23;
  localparam int WDT_PS_LSB      = 16;
  localparam int WDT_PS_W        = 5;
  localparam int CKSM_LSB        = 14;
  localparam int PBDIV_LSB       = 12;
  localparam int OSCIO_BIT       = 10;
  localparam int POSCMOD_LSB     = 8;
  localparam int TWO_SPEED_STARTUP_CFG_BIT        = 7;
  localparam int SOSC_BIT        = 5;
  localparam int FNOSC_LSB       = 0;

  // reserved bits forced to one: 31..24, 22..21, 11, 6, 4, 3
  localparam logic [31:0] RSVD_ONES_MASK = 32'hFF60_0858;

  // postscale limit
  localparam logic [4:0] WDT_PS_MAX = 5'h14;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : cfg_word_one_pkg

// file: core/wdt_ps_clamp.sv
// clamps the watchdog postscale code and expands it to a one-hot divide ratio
// assumes the code is stable while sampled
`timescale 1ns/10ps
module wdt_ps_clamp (
  input  wire logic [4:0]  code_in,
  output logic      [4:0]  code_eff,
  output logic      [20:0] ratio_onehot
);
  always_comb begin
    code_eff = (code_in > cfg_word_one_pkg::WDT_PS_MAX) ? cfg_word_one_pkg::WDT_PS_MAX : code_in;
    ratio_onehot = 21'h0_0001 << code_eff;
  end
endmodule : wdt_ps_clamp

// file: core/config_word_one_decode.sv
// decoder for the second configuration word, with an axi4-lite view
// assumes nv_word is stable from storage while rst_n is low and just after
//
// Overview of operation
// - a set force-enable bit keeps the watchdog running and software cannot stop it.
// - a clear force-enable bit leaves the watchdog off after reset but software may start it.
// - the five-bit postscale field selects a divide of two to the power of the code up to 1:1048576.
// - postscale codes above 10100 act as 10100.
// - a switch-monitor field with its upper bit set forbids clock switching and the fail-safe monitor.
// - switch-monitor field 01 allows clock switching with the fail-safe monitor off.
// - switch-monitor field 00 allows clock switching and turns the fail-safe monitor on.
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
module config_word_one_decode (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [31:0] nv_word,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             watchdog_run,
  output logic      [4:0]  watchdog_postscale_sel,
  output logic      [20:0] watchdog_ratio,
  output logic             clk_switch_allow,
  output logic             fail_safe_mon_en,
  output logic      [1:0]  peripheral_bus_divider_cfg,
  output logic             osc_pin_function_cfg,
  output logic      [1:0]  primary_osc_mode_cfg,
  output logic             two_speed_startup_cfg,
  output logic             secondary_osc_enable_cfg,
  output logic      [2:0]  initial_osc_select_cfg,
  output logic             osc_cfg_conflict
);

  // ==========================================================
  // state
  typedef struct packed {
    logic        loaded;
    logic [31:0] word;
    logic        sw_wdt_on;
    logic        wdt_run;
    logic [4:0]  ps;
    logic [20:0] ratio;
    logic        sw_ok;
    logic        fscm;
    logic        conflict;
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        aw_rdy;
    logic        w_rdy;
    logic        ar_rdy;
  } state_t;

  state_t st_q;
  state_t st_d;
  logic [4:0]  ps_eff;
  logic [20:0] ps_ratio;

  wdt_ps_clamp u_clamp (
    .code_in      (st_q.word[cfg_word_one_pkg::WDT_PS_LSB +: cfg_word_one_pkg::WDT_PS_W]),
    .code_eff     (ps_eff),
    .ratio_onehot (ps_ratio)
  );

  // ==========================================================
  // next state
  always_comb begin
    logic force_on;
    logic [1:0] cksm;
    logic do_wr;
    st_d     = st_q;
    force_on = st_q.word[cfg_word_one_pkg::WDT_FORCE_BIT];
    cksm     = st_q.word[cfg_word_one_pkg::CKSM_LSB +: 2];
    do_wr    = 1'b0;

    // capture the word in the first cycle after reset release
    if (!st_q.loaded) begin
      st_d.loaded = 1'b1;
      st_d.word   = nv_word | cfg_word_one_pkg::RSVD_ONES_MASK;
    end

    // axi write channel
    if (s_axi_awvalid && st_q.aw_rdy) begin
      st_d.aw_got  = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_q.w_rdy) begin
      st_d.w_got  = 1'b1;
      st_d.w_data = s_axi_wdata;
      st_d.w_strb = s_axi_wstrb;
    end
    if (st_q.aw_got && st_q.w_got && !st_q.bvalid) begin
      do_wr        = 1'b1;
      st_d.aw_got  = 1'b0;
      st_d.w_got   = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = (st_q.aw_addr == cfg_word_one_pkg::ADDR_WDT_CTRL ||
                      st_q.aw_addr == cfg_word_one_pkg::ADDR_CFG_WORD ||
                      st_q.aw_addr == cfg_word_one_pkg::ADDR_STATUS)
                     ? cfg_word_one_pkg::RESP_OKAY : cfg_word_one_pkg::RESP_SLVERR;
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    if (do_wr && st_q.aw_addr == cfg_word_one_pkg::ADDR_WDT_CTRL && st_q.w_strb[0]) begin
      st_d.sw_wdt_on = st_q.w_data[0];
    end

    // axi read channel
    if (s_axi_arvalid && st_q.ar_rdy) begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = cfg_word_one_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        cfg_word_one_pkg::ADDR_CFG_WORD: st_d.rdata = st_q.word;
        cfg_word_one_pkg::ADDR_WDT_CTRL: st_d.rdata = {31'h0, st_q.sw_wdt_on};
        cfg_word_one_pkg::ADDR_STATUS:   st_d.rdata = {26'h0, st_q.conflict, st_q.fscm, st_q.sw_ok,
                                                      st_q.wdt_run, force_on, st_q.loaded};
        default: begin
          st_d.rdata = 32'h0000_0000;
          st_d.rresp = cfg_word_one_pkg::RESP_SLVERR;
        end
      endcase
    end else if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end

    // registered ready flags: one write and one read in flight at a time
    // a channel reopens in the cycle after its response is taken
    st_d.aw_rdy = !st_d.aw_got && !st_d.bvalid;
    st_d.w_rdy  = !st_d.w_got && !st_d.bvalid;
    st_d.ar_rdy = !st_d.rvalid;

    // decode
    st_d.wdt_run  = st_q.loaded && (force_on || st_q.sw_wdt_on);
    st_d.ps       = ps_eff;
    st_d.ratio    = ps_ratio;
    st_d.sw_ok    = st_q.loaded && !cksm[1];
    st_d.fscm     = st_q.loaded && (cksm == 2'b00);
    // flags a word that disables the primary oscillator while it is the source
    st_d.conflict = st_q.loaded && (st_q.word[cfg_word_one_pkg::POSCMOD_LSB +: 2] == 2'b00) &&
                    (st_q.word[cfg_word_one_pkg::FNOSC_LSB +: 3] == 3'h2 ||
                     st_q.word[cfg_word_one_pkg::FNOSC_LSB +: 3] == 3'h3);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // outputs
  assign s_axi_awready              = st_q.aw_rdy;
  assign s_axi_wready               = st_q.w_rdy;
  assign s_axi_bresp                = st_q.bresp;
  assign s_axi_bvalid               = st_q.bvalid;
  assign s_axi_arready              = st_q.ar_rdy;
  assign s_axi_rdata                = st_q.rdata;
  assign s_axi_rresp                = st_q.rresp;
  assign s_axi_rvalid               = st_q.rvalid;
  assign watchdog_run               = st_q.wdt_run;
  assign watchdog_postscale_sel     = st_q.ps;
  assign watchdog_ratio             = st_q.ratio;
  assign clk_switch_allow           = st_q.sw_ok;
  assign fail_safe_mon_en           = st_q.fscm;
  assign peripheral_bus_divider_cfg = st_q.word[cfg_word_one_pkg::PBDIV_LSB +: 2];
  assign osc_pin_function_cfg       = st_q.word[cfg_word_one_pkg::OSCIO_BIT];
  assign primary_osc_mode_cfg       = st_q.word[cfg_word_one_pkg::POSCMOD_LSB +: 2];
  assign two_speed_startup_cfg      = st_q.word[cfg_word_one_pkg::TWO_SPEED_STARTUP_CFG_BIT];
  assign secondary_osc_enable_cfg   = st_q.word[cfg_word_one_pkg::SOSC_BIT];
  assign initial_osc_select_cfg     = st_q.word[cfg_word_one_pkg::FNOSC_LSB +: 3];
  assign osc_cfg_conflict           = st_q.conflict;

  // ==========================================================
  // checks on the decoded configuration
  wdt_forced_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(st_q.loaded) && st_q.word[cfg_word_one_pkg::WDT_FORCE_BIT] |=> watchdog_run)
    else $error("watchdog not running while forced");
  wdt_reset_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !st_q.loaded |=> !watchdog_run)
    else $error("watchdog on before capture");
  wdt_sw_on_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_q.loaded && st_q.sw_wdt_on |=> watchdog_run)
    else $error("software enable ignored");
  wdt_idle_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_q.loaded && !st_q.word[cfg_word_one_pkg::WDT_FORCE_BIT] && !st_q.sw_wdt_on |=> !watchdog_run)
    else $error("watchdog running without any enable");
  ps_ratio_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_q.loaded |-> watchdog_ratio == (21'h0_0001 << watchdog_postscale_sel))
    else $error("ratio does not match code");
  ps_unity_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_q.loaded && st_q.word[20:16] == 5'h00 |=> watchdog_ratio == 21'h0_0001)
    else $error("code zero not a divide by one");
  ps_top_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_q.loaded && st_q.word[20:16] == 5'h14 |=> watchdog_ratio == 21'h10_0000)
    else $error("top code not the largest divide");
  ps_code_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_q.loaded && st_q.word[20:16] <= cfg_word_one_pkg::WDT_PS_MAX |=>
      watchdog_postscale_sel == st_q.word[20:16])
    else $error("listed code not passed through");
  ps_clamp_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    watchdog_postscale_sel <= 5'h14)
    else $error("postscale above limit");
  ps_over_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_q.loaded && st_q.word[20:16] > cfg_word_one_pkg::WDT_PS_MAX |=>
      watchdog_postscale_sel == cfg_word_one_pkg::WDT_PS_MAX && watchdog_ratio == 21'h10_0000)
    else $error("large code not treated as top code");
  cksm_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(st_q.loaded) && st_q.word[15] |=> !clk_switch_allow && !fail_safe_mon_en)
    else $error("switching allowed with upper bit set");
  cksm_sw_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_q.loaded && st_q.word[15:14] == 2'b01 |=> clk_switch_allow && !fail_safe_mon_en)
    else $error("code 01 decoded wrong");
  cksm_fscm_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_q.loaded && st_q.word[15:14] == 2'b00 |=> clk_switch_allow && fail_safe_mon_en)
    else $error("code 00 decoded wrong");
  fscm_sw_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    fail_safe_mon_en |-> clk_switch_allow)
    else $error("monitor on without switching");
  conflict_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_q.loaded && st_q.word[9:8] == 2'b00 && st_q.word[2:1] == 2'b01 |=> osc_cfg_conflict)
    else $error("disabled primary source not flagged");
  conflict_clr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_q.loaded && st_q.word[9:8] != 2'b00 |=> !osc_cfg_conflict)
    else $error("conflict flagged with primary enabled");
  rsvd_ones_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_q.loaded |-> (st_q.word & 32'hFF60_0858) == 32'hFF60_0858)
    else $error("reserved bits not ones");
  rd_cfg_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_axi_arvalid && s_axi_arready && s_axi_araddr == cfg_word_one_pkg::ADDR_CFG_WORD |=>
      s_axi_rvalid && s_axi_rdata == st_q.word)
    else $error("word read back wrong");
  word_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_q.loaded |=> $stable(st_q.word))
    else $error("word changed after capture");
  fields_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_q.loaded |=> $stable(primary_osc_mode_cfg) && $stable(initial_osc_select_cfg) &&
      $stable(peripheral_bus_divider_cfg) && $stable(two_speed_startup_cfg))
    else $error("fields changed after capture");
  rst_outputs_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !st_q.loaded |-> !watchdog_run && !clk_switch_allow && !fail_safe_mon_en && !osc_cfg_conflict)
    else $error("decoded outputs active before capture");

  // ==========================================================
  // checks on the register bus
  aw_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_axi_awready && !s_axi_awvalid |=> s_axi_awready)
    else $error("write address ready dropped while idle");
  w_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_axi_wready && !s_axi_wvalid |=> s_axi_wready)
    else $error("write data ready dropped while idle");
  ar_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_axi_arready && !s_axi_arvalid |=> s_axi_arready)
    else $error("read address ready dropped while idle");
  b_done_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  r_done_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  one_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write taken during response");
  one_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_axi_rvalid |-> !s_axi_arready)
    else $error("new read taken during response");
  rd_bad_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_axi_arvalid && s_axi_arready && s_axi_araddr != cfg_word_one_pkg::ADDR_CFG_WORD &&
      s_axi_araddr != cfg_word_one_pkg::ADDR_WDT_CTRL && s_axi_araddr != cfg_word_one_pkg::ADDR_STATUS |=>
      s_axi_rresp == cfg_word_one_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  rd_status_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_axi_arvalid && s_axi_arready && s_axi_araddr == cfg_word_one_pkg::ADDR_STATUS |=>
      s_axi_rdata[0] && s_axi_rdata[1] == st_q.word[cfg_word_one_pkg::WDT_FORCE_BIT])
    else $error("status read wrong");
  rd_ctrl_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_axi_arvalid && s_axi_arready && s_axi_araddr == cfg_word_one_pkg::ADDR_WDT_CTRL |=>
      s_axi_rdata == {31'h0000_0000, $past(st_q.sw_wdt_on)})
    else $error("control read wrong");

endmodule : config_word_one_decode

// file: tb/config_word_one_decode_bench.sv
// self-checking bench for the second configuration word decoder
// assumes a single core_clk domain and the axi4-lite map of cfg_word_one_pkg
`timescale 1ns/10ps
module config_word_one_decode_bench;
  // ==========================================================
  // signals
  logic        core_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, watchdog_run;
  logic        clk_switch_allow, fail_safe_mon_en, osc_pin_function_cfg, two_speed_startup_cfg;
  logic        secondary_osc_enable_cfg, osc_cfg_conflict;
  logic [1:0]  s_axi_bresp, s_axi_rresp, peripheral_bus_divider_cfg, primary_osc_mode_cfg, resp;
  logic [2:0]  initial_osc_select_cfg;
  logic [3:0]  s_axi_wstrb;
  logic [4:0]  watchdog_postscale_sel;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [20:0] watchdog_ratio;
  logic [31:0] nv_word, s_axi_wdata, s_axi_rdata, seed, word, rd;
  int          err_total, compares;
  localparam logic [4:0] PS_TAB [8] = '{5'h00, 5'h14, 5'h15, 5'h1f, 5'h01, 5'h13, 5'h0a, 5'h1e};

  config_word_one_decode u_config_word_one_decode (
    .core_clk, .rst_n, .nv_word, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .watchdog_run,
    .watchdog_postscale_sel, .watchdog_ratio, .clk_switch_allow, .fail_safe_mon_en, .peripheral_bus_divider_cfg,
    .osc_pin_function_cfg, .primary_osc_mode_cfg, .two_speed_startup_cfg, .secondary_osc_enable_cfg,
    .initial_osc_select_cfg, .osc_cfg_conflict
  );

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // ==========================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  function automatic logic [4:0] ps_eff(input logic [4:0] c);
    return (c > cfg_word_one_pkg::WDT_PS_MAX) ? cfg_word_one_pkg::WDT_PS_MAX : c;
  endfunction : ps_eff

  task automatic end_sim;
    if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic waited(input bit hung);
    if (hung) begin
      chk("bus wait", 32'h1, 32'h0);
      end_sim();
    end
  endtask : waited

  // ==========================================================
  // bus cycles: pending flags are local, an edge always separates two calls
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw_p;
    bit w_p;
    bit b_p;
    int n;
    aw_p = 1'b1;
    w_p  = 1'b1;
    b_p  = 1'b1;
    n    = 0;
    r    = 2'h3;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while ((aw_p || w_p || b_p) && n < 100) begin
      @(posedge core_clk);
      n++;
      if (aw_p && s_axi_awready) begin
        aw_p = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_p && s_axi_wready) begin
        w_p = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      if (b_p && s_axi_bvalid) begin
        b_p = 1'b0;
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
    waited(aw_p || w_p || b_p);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ar_p;
    bit r_p;
    int n;
    ar_p = 1'b1;
    r_p  = 1'b1;
    n    = 0;
    d    = 32'hdead_0000;
    r    = 2'h3;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while ((ar_p || r_p) && n < 100) begin
      @(posedge core_clk);
      n++;
      if (ar_p && s_axi_arready) begin
        ar_p = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
      if (r_p && s_axi_rvalid) begin
        r_p = 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
    waited(ar_p || r_p);
  endtask : axi_rd

  // ==========================================================
  // main sequence: one reset and capture per word
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    rst_n = 1'b0;
    nv_word = 32'h0000_0000;
    err_total = 0;
    compares = 0;
    seed = 32'hc1e6_ecc6;
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      word = seed | cfg_word_one_pkg::RSVD_ONES_MASK;
      if (i < 8) begin
        word[20:16] = PS_TAB[i];
        word[23] = i[0];
        word[15:14] = 2'(i >> 1);
        if (i == 2) word[9:0] = 10'h0fa;
      end
      @(posedge core_clk);
      rst_n <= 1'b0;
      nv_word <= word;
      repeat (10) @(posedge core_clk);
      chk("ratio in reset", 32'(watchdog_ratio), 32'h0);
      rst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      nv_word <= ~word;
      repeat (2) @(posedge core_clk);
      chk("wdt run", 32'(watchdog_run), 32'(word[23]));
      chk("postscale", 32'(watchdog_postscale_sel), 32'(ps_eff(word[20:16])));
      chk("ratio", 32'(watchdog_ratio), 32'h1 << ps_eff(word[20:16]));
      chk("switch", 32'(clk_switch_allow), 32'(!word[15]));
      chk("monitor", 32'(fail_safe_mon_en), 32'(word[15:14] == 2'h0));
      chk("fields", 32'({peripheral_bus_divider_cfg, osc_pin_function_cfg, primary_osc_mode_cfg, two_speed_startup_cfg,
        secondary_osc_enable_cfg, initial_osc_select_cfg}),
        32'({word[13:12], word[10], word[9:8], word[7], word[5], word[2:0]}));
      chk("conflict", 32'(osc_cfg_conflict), 32'(word[2:1] == 2'h1 && word[9:8] == 2'h0));
      axi_wr(cfg_word_one_pkg::ADDR_CFG_WORD, ~word, resp);
      chk("cfg wr resp", 32'(resp), 32'(cfg_word_one_pkg::RESP_OKAY));
      axi_rd(cfg_word_one_pkg::ADDR_CFG_WORD, rd, resp);
      chk("cfg word", rd, word);
      chk("cfg resp", 32'(resp), 32'(cfg_word_one_pkg::RESP_OKAY));
      axi_wr(cfg_word_one_pkg::ADDR_WDT_CTRL, 32'(!word[23]), resp);
      repeat (2) @(posedge core_clk);
      chk("wdt run sw", 32'(watchdog_run), 32'h1);
      axi_rd(cfg_word_one_pkg::ADDR_WDT_CTRL, rd, resp);
      chk("wdt ctrl", rd, 32'(!word[23]));
      axi_rd(8'h0c + {seed[7:6], 4'h0}, rd, resp);
      chk("unmapped", 32'(resp), 32'(cfg_word_one_pkg::RESP_SLVERR));
      chk("unmapped data", rd, 32'h0000_0000);
      axi_rd(cfg_word_one_pkg::ADDR_STATUS, rd, resp);
      chk("status", rd, 32'({word[2:1] == 2'h1 && word[9:8] == 2'h0, word[15:14] == 2'h0, !word[15], 1'b1,
        word[23], 1'b1}));
    end
    end_sim();
  end
endmodule : config_word_one_decode_bench
